// ### rtl/config_reset_seq.sv
`timescale 1ns/1ps
`include "cfg_defines.svh"
module config_reset_seq
  import cfg_types_pkg::*;
#(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = `POWERUP_DELAY_TIMER_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // supply monitors and pins, asynchronous
  input wire logic supply_ok,
  input wire logic brownout_low,
  input wire logic ext_reset_pin_n,
  input wire logic vpp_high,
  input wire logic osc_input_pin,
  // serial programming pins
  input wire logic prog_clock_pin,
  input wire logic prog_data_pin_i,
  output logic prog_data_pin_o,
  output logic prog_data_pin_oe,
  // core events, same clock
  input wire logic watchdog_reset,
  input wire logic sleep_wake,
  // reset and oscillator control
  output logic core_reset_n,
  output logic osc_stop,
  output logic prog_mode,
  output logic erase_data_mem,
  output logic erase_program_mem,
  // decoded configuration
  output logic [1:0] bandgap_trim,
  output logic data_protect_on,
  output logic program_protect_on,
  output logic brownout_enable,
  output logic reset_pin_select,
  output logic powerup_delay_on,
  output logic watchdog_enable,
  output logic [2:0] clock_source_select,
  output logic clock_output_function
);

  localparam int SYNC_W = 7;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic osc_prev;
    logic vpp_prev;
    seq_state_t st;
    logic [20:0] cnt;
    logic [13:0] cfg;
    logic [`ID_WORDS-1:0][`ID_WORD_BITS-1:0] id;
    logic prog_mode;
    logic core_reset_n;
    logic osc_stop;
    logic erase_data;
    logic erase_prog;
  } top_t;

  top_t s_q, s_d;
  prog_link_if lnk ();

  logic supply_s, bod_low_s, pin_n_s, vpp_s, osc_s;
  logic bod_on, powerup_delay_timer_on, xtal, int_or_rc, ext_hold, bod_trip, osc_rise;
  logic in_id;
  clk_src_t src;

  // ----------------------------------------
  // synchronised pins
  // ----------------------------------------
  assign supply_s = s_q.s2[0];
  assign bod_low_s = s_q.s2[1];
  assign pin_n_s = s_q.s2[2];
  assign vpp_s = s_q.s2[3];
  assign osc_s = s_q.s2[4];
  assign lnk.clk_sync = s_q.s2[5];
  assign lnk.data_sync = s_q.s2[6];

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  assign src = clk_src_t'(s_q.cfg[`CFG_CS_HI:`CFG_CS_LO]);
  assign bod_on = s_q.cfg[`CFG_BOD_BIT];
  assign powerup_delay_timer_on = !s_q.cfg[`CFG_POWERUP_DELAY_TIMER_N_BIT];
  assign xtal = (src == CS_LOW_POWER_XTAL) || (src == CS_STD_XTAL)
             || (src == CS_HIGH_SPEED_XTAL);
  assign int_or_rc = (src == CS_INT_OSC_IO) || (src == CS_INT_OSC_CLOCK_OUTPUT_FUNCTION)
                  || (src == CS_RC_OSC_IO) || (src == CS_RC_OSC_CLOCK_OUTPUT_FUNCTION);
  assign ext_hold = s_q.cfg[`CFG_RPSEL_BIT] && !pin_n_s;
  assign bod_trip = bod_on && bod_low_s;
  assign osc_rise = osc_s && !s_q.osc_prev;
  assign in_id = (lnk.addr >= `CFG_SPACE_BASE) && (lnk.addr <= `ID_ADDR_LAST);

  // ----------------------------------------
  // configuration store readback
  // ----------------------------------------
  always_comb begin
    lnk.rd_data = 14'h0;
    if (lnk.addr == `CFGW_ADDR) begin
      lnk.rd_data = s_q.cfg;
    end else if (in_id) begin
      lnk.rd_data = {7'h0, s_q.id[lnk.addr[1:0]]};
    end
  end
  assign lnk.active = s_q.prog_mode;

  // ----------------------------------------
  // reset sequencer and store
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.s1 = {prog_data_pin_i, prog_clock_pin, osc_input_pin, vpp_high,
              ext_reset_pin_n, brownout_low, supply_ok};
    s_d.s2 = s_q.s1;
    s_d.osc_prev = osc_s;
    s_d.vpp_prev = vpp_s;
    s_d.erase_data = 1'b0;
    s_d.erase_prog = 1'b0;
    // entry needs both serial pins low as vpp rises
    if (vpp_s && !s_q.vpp_prev && !lnk.clk_sync && !lnk.data_sync) begin
      s_d.prog_mode = 1'b1;
    end else if (!vpp_s) begin
      s_d.prog_mode = 1'b0;
    end
    if (lnk.wr_stb && s_q.prog_mode) begin
      if (lnk.addr == `CFGW_ADDR) begin
        s_d.cfg = lnk.wr_data & `CFGW_IMPL_MASK;
        // lifting protection wipes the arrays; the bandgap calibration bits keep the value written
        s_d.erase_data = lnk.wr_data[`CFG_DPROT_BIT] && !s_q.cfg[`CFG_DPROT_BIT];
        s_d.erase_prog = lnk.wr_data[`CFG_PPROT_BIT] && !s_q.cfg[`CFG_PPROT_BIT];
      end else if (in_id) begin
        s_d.id[lnk.addr[1:0]] = lnk.wr_data[`ID_WORD_BITS-1:0];
      end
    end
    unique case (s_q.st)
      SEQ_POR: begin
        s_d.cnt = 21'h0;
        if (supply_s && !bod_trip) begin
          if (powerup_delay_timer_on) begin
            s_d.st = SEQ_POWERUP_DELAY_TIMER;
          end else if (xtal) begin
            s_d.st = SEQ_OST;
          end else begin
            s_d.st = SEQ_RUN;
          end
        end
      end
      SEQ_POWERUP_DELAY_TIMER: begin
        s_d.cnt = s_q.cnt + 21'h1;
        if (s_q.cnt == 21'(POWERUP_DELAY_TIMER_CYCLES - 1)) begin
          s_d.cnt = 21'h0;
          s_d.st = xtal ? SEQ_OST : SEQ_RUN;
        end
      end
      SEQ_OST: begin
        if (osc_rise) begin
          s_d.cnt = s_q.cnt + 21'h1;
          if (s_q.cnt == 21'(`OST_CYCLES - 1)) begin
            s_d.cnt = 21'h0;
            s_d.st = SEQ_RUN;
          end
        end
      end
      SEQ_RUN: begin
        s_d.cnt = 21'h0;
        // supply falling alone does not restart the sequence
        if (sleep_wake && xtal) begin
          s_d.st = SEQ_OST;
        end
      end
      default: s_d.st = SEQ_POR;
    endcase
    if (bod_trip) begin
      s_d.st = SEQ_POR;
      s_d.cnt = 21'h0;
    end
    // watchdog only resets inside; the pin is never driven
    s_d.core_reset_n = (s_d.st == SEQ_RUN) && !ext_hold && !watchdog_reset
                    && !s_d.prog_mode;
    s_d.osc_stop = ext_hold && int_or_rc;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q <= '{s1: '0, s2: '0, osc_prev: 1'b0, vpp_prev: 1'b0, st: SEQ_POR,
               cnt: 21'h0, cfg: `CFGW_RESET, id: '0, prog_mode: 1'b0,
               core_reset_n: 1'b0, osc_stop: 1'b0, erase_data: 1'b0,
               erase_prog: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  serial_prog_port u_port (
    .mclk(mclk),
    .rst_n(rst_n),
    .lnk(lnk.port)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prog_data_pin_o = lnk.data_out;
  assign prog_data_pin_oe = lnk.data_oe;
  assign core_reset_n = s_q.core_reset_n;
  assign osc_stop = s_q.osc_stop;
  assign prog_mode = s_q.prog_mode;
  assign erase_data_mem = s_q.erase_data;
  assign erase_program_mem = s_q.erase_prog;
  assign bandgap_trim = s_q.cfg[`CFG_BG_HI:`CFG_BG_LO];
  assign data_protect_on = !s_q.cfg[`CFG_DPROT_BIT];
  assign program_protect_on = !s_q.cfg[`CFG_PPROT_BIT];
  assign brownout_enable = bod_on;
  assign reset_pin_select = s_q.cfg[`CFG_RPSEL_BIT];
  assign powerup_delay_on = powerup_delay_timer_on;
  assign watchdog_enable = s_q.cfg[`CFG_WDT_BIT];
  assign clock_source_select = s_q.cfg[`CFG_CS_HI:`CFG_CS_LO];
  assign clock_output_function = (src == CS_RC_OSC_CLOCK_OUTPUT_FUNCTION) || (src == CS_INT_OSC_CLOCK_OUTPUT_FUNCTION);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_unimpl_zero;
    @(posedge mclk) disable iff (!rst_n)
    s_q.cfg[11:9] == 3'h0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("bits 11-9 set");

  property p_no_access_run;
    @(posedge mclk) disable iff (!rst_n)
    !s_q.prog_mode |=> $stable(s_q.cfg) && $stable(s_q.id);
  endproperty
  a_no_access_run: assert property (p_no_access_run) else $error("store changed");

  property p_osc_stop;
    @(posedge mclk) disable iff (!rst_n)
    (ext_hold && int_or_rc) |=> osc_stop && !core_reset_n;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator not stopped");

  property p_wdt_internal;
    @(posedge mclk) disable iff (!rst_n)
    (watchdog_reset && s_q.st == SEQ_RUN && !bod_trip && !(sleep_wake && xtal))
      |=> !core_reset_n && s_q.st == SEQ_RUN;
  endproperty
  a_wdt_internal: assert property (p_wdt_internal) else $error("watchdog reset wrong");

  property p_bod_hold;
    @(posedge mclk) disable iff (!rst_n)
    bod_trip |=> s_q.st == SEQ_POR && !core_reset_n;
  endproperty
  a_bod_hold: assert property (p_bod_hold) else $error("brownout not held");

  property p_no_fall_por;
    @(posedge mclk) disable iff (!rst_n)
    (s_q.st == SEQ_RUN && !bod_trip && !(sleep_wake && xtal)) |=> s_q.st == SEQ_RUN;
  endproperty
  a_no_fall_por: assert property (p_no_fall_por) else $error("left run state");

  property p_powerup_delay_timer_bound;
    @(posedge mclk) disable iff (!rst_n)
    s_q.st == SEQ_POWERUP_DELAY_TIMER |-> s_q.cnt < 21'(POWERUP_DELAY_TIMER_CYCLES) && !core_reset_n;
  endproperty
  a_powerup_delay_timer_bound: assert property (p_powerup_delay_timer_bound) else $error("delay timer overrun");

  property p_ost_bound;
    @(posedge mclk) disable iff (!rst_n)
    s_q.st == SEQ_OST |-> s_q.cnt < 21'(`OST_CYCLES);
  endproperty
  a_ost_bound: assert property (p_ost_bound) else $error("start-up count overrun");

  property p_ost_xtal;
    @(posedge mclk) disable iff (!rst_n)
    $rose(s_q.st == SEQ_OST) |-> xtal;
  endproperty
  a_ost_xtal: assert property (p_ost_xtal) else $error("start-up timer wrong mode");

  property p_erase;
    @(posedge mclk) disable iff (!rst_n)
    $rose(s_q.cfg[`CFG_PPROT_BIT]) |-> erase_program_mem;
  endproperty
  a_erase: assert property (p_erase) else $error("no erase on unprotect");

  property p_release;
    @(posedge mclk) disable iff (!rst_n)
    $rose(core_reset_n) |-> s_q.st == SEQ_RUN && !s_q.prog_mode && !osc_stop;
  endproperty
  a_release: assert property (p_release) else $error("early release");

  c_run: cover property (@(posedge mclk) disable iff (!rst_n) $rose(core_reset_n));
  c_prog: cover property (@(posedge mclk) disable iff (!rst_n) $rose(s_q.prog_mode));
  c_ost: cover property (@(posedge mclk) disable iff (!rst_n) $rose(s_q.st == SEQ_OST));
  c_erase: cover property (@(posedge mclk) disable iff (!rst_n) erase_data_mem);

endmodule

// ### shared/cfg_defines.svh
`ifndef CFG_DEFINES_SVH
`define CFG_DEFINES_SVH

// ----------------------------------------
// configuration space map
// ----------------------------------------
`define CFG_SPACE_BASE 14'h2000
`define ID_ADDR_LAST 14'h2003
`define CFGW_ADDR 14'h2007
`define PC_ENTRY 14'h0000
`define ID_WORD_BITS 7
`define ID_WORDS 4

// ----------------------------------------
// configuration word fields and reset
// ----------------------------------------
`define CFGW_RESET 14'h31ff
`define CFGW_IMPL_MASK 14'h31ff
`define CFG_BG_HI 13
`define CFG_BG_LO 12
`define CFG_DPROT_BIT 8
`define CFG_PPROT_BIT 7
`define CFG_BOD_BIT 6
`define CFG_RPSEL_BIT 5
`define CFG_POWERUP_DELAY_TIMER_N_BIT 4
`define CFG_WDT_BIT 3
`define CFG_CS_HI 2
`define CFG_CS_LO 0

// ----------------------------------------
// timing
// ----------------------------------------
`define MCLK_HZ 25000000
`define POWERUP_DELAY_TIMER_MS 72
`define POWERUP_DELAY_TIMER_CYCLES (`POWERUP_DELAY_TIMER_MS * (`MCLK_HZ / 1000))
`define OST_CYCLES 1024

// ----------------------------------------
// serial programming link
// ----------------------------------------
`define CMD_BITS 6
`define DATA_BITS 14
`define CMD_LOAD_CFG 6'h00
`define CMD_LOAD_DATA 6'h02
`define CMD_READ_DATA 6'h04
`define CMD_INC_ADDR 6'h06

`endif

// ### shared/cfg_types_pkg.sv
package cfg_types_pkg;

  typedef enum logic [3:0] {
    SEQ_POR = 4'b0001,
    SEQ_POWERUP_DELAY_TIMER = 4'b0010,
    SEQ_OST = 4'b0100,
    SEQ_RUN = 4'b1000
  } seq_state_t;

  typedef enum logic [2:0] {
    SP_CMD = 3'b001,
    SP_LOAD = 3'b010,
    SP_READ = 3'b100
  } ser_state_t;

  typedef enum logic [2:0] {
    CS_LOW_POWER_XTAL = 3'h0,
    CS_STD_XTAL = 3'h1,
    CS_HIGH_SPEED_XTAL = 3'h2,
    CS_EXT_CLOCK_IN = 3'h3,
    CS_INT_OSC_IO = 3'h4,
    CS_INT_OSC_CLOCK_OUTPUT_FUNCTION = 3'h5,
    CS_RC_OSC_IO = 3'h6,
    CS_RC_OSC_CLOCK_OUTPUT_FUNCTION = 3'h7
  } clk_src_t;

endpackage

// ### shared/prog_link_if.sv
`timescale 1ns/1ps
interface prog_link_if;
  logic clk_sync;
  logic data_sync;
  logic active;
  logic [13:0] addr;
  logic wr_stb;
  logic [13:0] wr_data;
  logic [13:0] rd_data;
  logic data_out;
  logic data_oe;

  modport port (
    input clk_sync, data_sync, active, rd_data,
    output addr, wr_stb, wr_data, data_out, data_oe
  );
  modport store (
    output clk_sync, data_sync, active, rd_data,
    input addr, wr_stb, wr_data, data_out, data_oe
  );
endinterface

// ### rtl/serial_prog_port.sv
`timescale 1ns/1ps
`include "cfg_defines.svh"
module serial_prog_port
  import cfg_types_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link to the configuration store
  prog_link_if.port lnk
);

  typedef struct packed {
    logic clk_prev;
    ser_state_t st;
    logic [4:0] bits;
    logic [13:0] sh;
    logic [13:0] addr;
    logic wr_stb;
    logic data_out;
  } ser_t;

  ser_t s_q, s_d;
  logic rise;
  logic [5:0] cmd_now;

  assign rise = lnk.clk_sync && !s_q.clk_prev;
  assign cmd_now = {lnk.data_sync, s_q.sh[13:9]};

  // ----------------------------------------
  // command and data shifter, lsb first
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.clk_prev = lnk.clk_sync;
    s_d.wr_stb = 1'b0;
    if (!lnk.active) begin
      s_d.st = SP_CMD;
      s_d.bits = 5'h0;
      s_d.addr = `PC_ENTRY;
      s_d.data_out = 1'b0;
    end else if (rise) begin
      unique case (s_q.st)
        SP_CMD: begin
          s_d.sh = {lnk.data_sync, s_q.sh[13:1]};
          s_d.bits = s_q.bits + 5'h1;
          if (s_q.bits == 5'(`CMD_BITS - 1)) begin
            s_d.bits = 5'h0;
            unique case (cmd_now)
              `CMD_LOAD_CFG: begin
                s_d.addr = `CFG_SPACE_BASE;
                s_d.st = SP_LOAD;
              end
              `CMD_LOAD_DATA: s_d.st = SP_LOAD;
              `CMD_READ_DATA: begin
                s_d.st = SP_READ;
                s_d.sh = lnk.rd_data;
                s_d.data_out = lnk.rd_data[0];
              end
              `CMD_INC_ADDR: s_d.addr = s_q.addr + 14'h1;
              default: s_d.st = SP_CMD;
            endcase
          end
        end
        SP_LOAD: begin
          s_d.sh = {lnk.data_sync, s_q.sh[13:1]};
          s_d.bits = s_q.bits + 5'h1;
          if (s_q.bits == 5'(`DATA_BITS - 1)) begin
            s_d.wr_stb = 1'b1;
            s_d.bits = 5'h0;
            s_d.st = SP_CMD;
          end
        end
        SP_READ: begin
          s_d.sh = {1'b0, s_q.sh[13:1]};
          s_d.data_out = s_q.sh[1];
          s_d.bits = s_q.bits + 5'h1;
          if (s_q.bits == 5'(`DATA_BITS - 1)) begin
            s_d.bits = 5'h0;
            s_d.data_out = 1'b0;
            s_d.st = SP_CMD;
          end
        end
        default: s_d.st = SP_CMD;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q <= '{clk_prev: 1'b0, st: SP_CMD, bits: 5'h0, sh: 14'h0,
               addr: 14'h0, wr_stb: 1'b0, data_out: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.addr = s_q.addr;
  assign lnk.wr_stb = s_q.wr_stb;
  assign lnk.wr_data = s_q.sh;
  assign lnk.data_out = s_q.data_out;
  assign lnk.data_oe = (s_q.st == SP_READ);

  property p_pc_entry;
    @(posedge mclk) disable iff (!rst_n)
    $rose(lnk.active) |-> s_q.addr == `PC_ENTRY;
  endproperty
  a_pc_entry: assert property (p_pc_entry) else $error("pc not at entry");

endmodule

// ### tb/prog_host.sv
`timescale 1ns/1ps
module prog_host (
  // clock
  input wire logic mclk,
  // programming pins
  output logic vpp_high,
  output logic prog_clock_pin,
  output logic data_drv,
  input wire logic data_line
);
  // ----------------------------------------
  // serial programmer, 320 ns link period
  // ----------------------------------------
  initial begin
    vpp_high = 1'b0;
    prog_clock_pin = 1'b0;
    data_drv = 1'b0;
  end

  task automatic half();
    repeat (4) @(posedge mclk);
  endtask

  // clock and data low while vpp rises
  task automatic enter();
    prog_clock_pin <= 1'b0;
    data_drv <= 1'b0;
    half();
    vpp_high <= 1'b1;
    repeat (4) half();
  endtask

  task automatic leave();
    vpp_high <= 1'b0;
    repeat (4) half();
  endtask

  // lsb first, link clock still between frames
  task automatic shift(input logic [13:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      data_drv <= v[i];
      half();
      prog_clock_pin <= 1'b1;
      half();
      prog_clock_pin <= 1'b0;
    end
    half();
  endtask

  task automatic cmd(input logic [5:0] c);
    shift({8'h00, c}, 6);
  endtask

  task automatic word(input logic [13:0] w);
    shift(w, 14);
  endtask

  // released line flips so a stale level never reads back
  task automatic read(output logic [13:0] w);
    data_drv <= ~data_drv;
    for (int i = 0; i < 14; i++) begin
      half();
      w[i] = data_line;
      prog_clock_pin <= 1'b1;
      half();
      prog_clock_pin <= 1'b0;
    end
    half();
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "cfg_defines.svh"
module testbench
  import cfg_types_pkg::*;
;
  localparam int POWERUP_DELAY_TIMER = 40;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_ok = 1'b0;
  logic brownout_low = 1'b0;
  logic ext_reset_pin_n = 1'b1;
  logic osc_input_pin = 1'b0;
  logic osc_en = 1'b0;
  logic [1:0] osc_div = 2'h0;
  logic watchdog_reset = 1'b0;
  logic sleep_wake = 1'b0;
  logic vpp_high;
  logic prog_clock_pin;
  logic data_drv;
  logic data_line;
  logic prog_data_pin_o;
  logic prog_data_pin_oe;
  logic core_reset_n;
  logic osc_stop;
  logic prog_mode;
  logic erase_data_mem;
  logic erase_program_mem;
  logic [1:0] bandgap_trim;
  logic data_protect_on;
  logic program_protect_on;
  logic brownout_enable;
  logic reset_pin_select;
  logic powerup_delay_on;
  logic watchdog_enable;
  logic [2:0] clock_source_select;
  logic clock_output_function;
  logic [11:0] dec;
  int err_count = 0;
  int tests_run = 0;
  int n_erase_d = 0;
  int n_erase_p = 0;

  always #20 mclk = ~mclk;

  always @(posedge mclk) begin
    osc_div <= osc_div + 2'h1;
    osc_input_pin <= osc_en & osc_div[1];
    if (erase_data_mem === 1'b1) n_erase_d++;
    if (erase_program_mem === 1'b1) n_erase_p++;
  end

  assign data_line = prog_data_pin_oe ? prog_data_pin_o : data_drv;
  assign dec = {bandgap_trim, data_protect_on, program_protect_on, brownout_enable,
                reset_pin_select, powerup_delay_on, watchdog_enable,
                clock_source_select, clock_output_function};

  config_reset_seq #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER)) DUT (
    .mclk(mclk), .rst_n(rst_n), .supply_ok(supply_ok), .brownout_low(brownout_low),
    .ext_reset_pin_n(ext_reset_pin_n), .vpp_high(vpp_high), .osc_input_pin(osc_input_pin),
    .prog_clock_pin(prog_clock_pin), .prog_data_pin_i(data_line),
    .prog_data_pin_o(prog_data_pin_o), .prog_data_pin_oe(prog_data_pin_oe),
    .watchdog_reset(watchdog_reset), .sleep_wake(sleep_wake), .core_reset_n(core_reset_n),
    .osc_stop(osc_stop), .prog_mode(prog_mode), .erase_data_mem(erase_data_mem),
    .erase_program_mem(erase_program_mem), .bandgap_trim(bandgap_trim),
    .data_protect_on(data_protect_on), .program_protect_on(program_protect_on),
    .brownout_enable(brownout_enable), .reset_pin_select(reset_pin_select),
    .powerup_delay_on(powerup_delay_on), .watchdog_enable(watchdog_enable),
    .clock_source_select(clock_source_select), .clock_output_function(clock_output_function)
  );

  prog_host host (
    .mclk(mclk), .vpp_high(vpp_high), .prog_clock_pin(prog_clock_pin),
    .data_drv(data_drv), .data_line(data_line)
  );

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic check(input logic [13:0] got, input logic [13:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_run(output int n);
    n = 0;
    while (core_reset_n !== 1'b1 && n < 9000) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task automatic ld(input logic [13:0] w);
    host.cmd(`CMD_LOAD_DATA);
    host.word(w);
  endtask

  task automatic rd(output logic [13:0] w);
    host.cmd(`CMD_READ_DATA);
    host.read(w);
  endtask

  task automatic final_report();
    $display("checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_power_on();
    int n;
    check(14'(dec), 14'hcdf, "reset decode");
    repeat (20) @(posedge mclk);
    check(14'(core_reset_n), 14'h0, "no supply");
    supply_ok <= 1'b1;
    wait_run(n);
    check(14'(n <= 8), 14'h1, "fast release");
    supply_ok <= 1'b0;
    repeat (20) @(posedge mclk);
    check(14'(core_reset_n), 14'h1, "supply fall");
    supply_ok <= 1'b1;
  endtask

  task automatic t_ext_pin();
    int n;
    ext_reset_pin_n <= 1'b0;
    repeat (6) @(posedge mclk);
    check(14'(core_reset_n), 14'h0, "pin reset");
    check(14'(osc_stop), 14'h1, "osc stop");
    ext_reset_pin_n <= 1'b1;
    wait_run(n);
    check(14'(n <= 8), 14'h1, "pin release");
    check(14'(osc_stop), 14'h0, "osc run");
  endtask

  task automatic t_watchdog();
    @(posedge mclk);
    watchdog_reset <= 1'b1;
    @(posedge mclk);
    watchdog_reset <= 1'b0;
    @(posedge mclk);
    check(14'(core_reset_n), 14'h0, "wdt reset");
    check(14'(prog_data_pin_oe), 14'h0, "pin idle");
    @(posedge mclk);
    check(14'(core_reset_n), 14'h1, "wdt one cycle");
  endtask

  task automatic t_program();
    logic [13:0] w;
    ld(14'h0000);
    host.enter();
    check(14'(prog_mode), 14'h1, "prog mode");
    check(14'(core_reset_n), 14'h0, "core held");
    host.cmd(`CMD_LOAD_CFG);
    host.word(14'h3fff);
    rd(w);
    check(w, 14'h007f, "id word");
    repeat (7) host.cmd(`CMD_INC_ADDR);
    rd(w);
    check(w, `CFGW_RESET, "config unchanged");
    ld(14'h2e61);
    rd(w);
    check(w, 14'h2061, "config word");
    check(14'(dec), 14'hbe2, "decode");
    check(14'(n_erase_d + n_erase_p), 14'h0, "no erase");
    for (int cs = 0; cs < 8; cs++) begin
      ld(14'(14'h31e0 | cs));
      check(14'({clock_source_select, clock_output_function}),
            14'({cs[2:0], cs == 5 || cs == 7}), "clock source");
    end
    check(14'(n_erase_d), 14'h1, "data erase");
    check(14'(n_erase_p), 14'h1, "program erase");
    ld(14'h31e1);
    osc_en <= 1'b1;
    host.leave();
    check(14'(prog_mode), 14'h0, "mode left");
  endtask

  // crystal source with delay timer and brownout, as a programmer should set
  task automatic t_sequence();
    int n;
    brownout_low <= 1'b1;
    repeat (6) @(posedge mclk);
    check(14'(core_reset_n), 14'h0, "brownout hold");
    brownout_low <= 1'b0;
    wait_run(n);
    check(14'(n >= POWERUP_DELAY_TIMER + 4088 && n <= POWERUP_DELAY_TIMER + 4120), 14'h1, "delay then start");
  endtask

  task automatic t_wake();
    int n;
    sleep_wake <= 1'b1;
    @(posedge mclk);
    sleep_wake <= 1'b0;
    repeat (3) @(posedge mclk);
    check(14'(core_reset_n), 14'h0, "wake hold");
    wait_run(n);
    check(14'(n >= 4080 && n <= 4120), 14'h1, "wake start count");
    ext_reset_pin_n <= 1'b0;
    repeat (6) @(posedge mclk);
    check(14'(osc_stop), 14'h0, "crystal keeps osc");
    ext_reset_pin_n <= 1'b1;
  endtask

  // reset pin as plain i/o and brownout off: neither may hold the core
  task automatic t_pin_io();
    host.enter();
    host.cmd(`CMD_LOAD_CFG);
    host.word(14'h0000);
    repeat (7) host.cmd(`CMD_INC_ADDR);
    host.cmd(6'h3f);
    ld(14'h3184);
    host.leave();
    check(14'(dec), 14'hc28, "i/o decode");
    ext_reset_pin_n <= 1'b0;
    brownout_low <= 1'b1;
    repeat (6) @(posedge mclk);
    check(14'({core_reset_n, osc_stop}), 14'h2, "pin and brownout ignored");
    ext_reset_pin_n <= 1'b1;
    brownout_low <= 1'b0;
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_power_on();
    t_ext_pin();
    t_watchdog();
    t_program();
    t_sequence();
    t_wake();
    t_pin_io();
    final_report();
  end

  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    $display("wrong value at %0t: run timed out", $time);
    final_report();
  end
endmodule
